// *** logic/pvcar_regs.v ***
// Port VC control, status and VC resource 0 capability registers on APB
//
// Overview of operation
// RULE1: Table load bit, control bit 0, always reads zero whatever was written.
// RULE2: Writing the table load bit changes nothing in the port.
// RULE3: Scheme select, control bits 3:1, read-write, resets zero, steers no arbitration.
// RULE4: Table status bit, status bit 0, always reads zero.
// RULE5: Port arbitration capability reads 0x3 upstream, 0x1 downstream.
// RULE6: Each capability bit names one arbitration scheme; several may be set.
// RULE7: Advanced switching capability, bit 14, reads zero.
// RULE8: Reject snoop capability, bit 15, reads zero.
// RULE9: Maximum time slots, bits 22:16, reads zero.
// RULE10: Table offset, bits 31:24, in 16-byte units, reads 0x2 upstream.
// RULE11: Table offset reads 0x0 on downstream ports.
// RULE12: Writes to read-only and reserved bits ignored; reserved bits read zero.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pvcar_defs.vh"
module pvcar_regs (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PVCAR_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Port role strap, high on the upstream port
   input wire port_is_upstream,
   // Configuration seen by the port
   output reg [2:0] vc_scheme_select,
   output reg [7:0] port_arb_capability,
   output reg [7:0] port_arb_table_offset
);
   wire upstream;
   wire setup;
   wire wr_commit;
   wire sel_ctl;
   wire sel_sts;
   wire sel_cap;
   wire mapped;
   reg [2:0] next_vc_scheme_select;
   reg [31:0] next_prdata;
   reg [31:0] cap_word;
   reg [7:0] next_arb_cap;
   reg [7:0] next_tbl_off;

   // Strap comes from a pin, so it is synchronised before use
   pvcar_sync u_strap_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(port_is_upstream),
      .dout(upstream)
   );

   assign setup = psel & ~penable;
   assign wr_commit = psel & penable & pready & pwrite;
   assign sel_ctl = (paddr == `PVCAR_ADDR_PORT_VC_CONTROL);
   assign sel_sts = (paddr == `PVCAR_ADDR_PORT_VC_STATUS);
   assign sel_cap = (paddr == `PVCAR_ADDR_VC_RES0_CAP);
   assign mapped = sel_ctl | sel_sts | sel_cap;

   // Role-dependent capability values
   always @* begin
      if (upstream) begin
         next_arb_cap = `PVCAR_ARB_CAP_UP; // [RULE5] [RULE6]
         next_tbl_off = `PVCAR_TBL_OFF_UP; // [RULE10]
      end else begin
         next_arb_cap = `PVCAR_ARB_CAP_DOWN; // [RULE5]
         next_tbl_off = `PVCAR_TBL_OFF_DOWN; // [RULE11]
      end
   end

   always @* begin
      cap_word = 32'h00000000; // [RULE12]
      cap_word[`PVCAR_CAP_ARB_MSB:`PVCAR_CAP_ARB_LSB] = next_arb_cap;
      cap_word[`PVCAR_CAP_ADV_SWITCH_BIT] = 1'b0; // [RULE7]
      cap_word[`PVCAR_CAP_REJECT_SNOOP_BIT] = 1'b0; // [RULE8]
      cap_word[`PVCAR_CAP_MAX_SLOTS_MSB:`PVCAR_CAP_MAX_SLOTS_LSB] = `PVCAR_MAX_SLOTS; // [RULE9]
      cap_word[`PVCAR_CAP_TBL_OFF_MSB:`PVCAR_CAP_TBL_OFF_LSB] = next_tbl_off; // [RULE10]
   end

   // Read mux, captured in the setup cycle
   always @* begin
      next_prdata = 32'h00000000;
      if (sel_ctl) begin
         next_prdata[`PVCAR_CTL_SCHEME_MSB:`PVCAR_CTL_SCHEME_LSB] = vc_scheme_select; // [RULE3]
         next_prdata[`PVCAR_CTL_TABLE_LOAD_BIT] = 1'b0; // [RULE1]
      end else if (sel_sts) begin
         next_prdata[`PVCAR_STS_TABLE_STATUS_BIT] = 1'b0; // [RULE4]
      end else if (sel_cap) begin
         next_prdata = cap_word;
      end
   end

   // Only the selector bits take a write; the load bit has no storage
   always @* begin
      next_vc_scheme_select = vc_scheme_select;
      if (wr_commit && sel_ctl && pstrb[0]) begin
         next_vc_scheme_select = pwdata[`PVCAR_CTL_SCHEME_MSB:`PVCAR_CTL_SCHEME_LSB]; // [RULE3] [RULE2] [RULE12]
      end
   end

   // Zero-wait slave: ready comes in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
         end else if (!psel) begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vc_scheme_select <= `PVCAR_CTL_SCHEME_RESET; // [RULE3]
         port_arb_capability <= 8'h00;
         port_arb_table_offset <= 8'h00;
      end else begin
         vc_scheme_select <= next_vc_scheme_select;
         port_arb_capability <= next_arb_cap;
         port_arb_table_offset <= next_tbl_off;
      end
   end
endmodule // pvcar_regs
`default_nettype wire

// *** logic/pvcar_sync.v ***
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pvcar_sync (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Level in and out
   input wire din,
   output reg dout
);
   reg stage1;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // pvcar_sync
`default_nettype wire

// *** pkg/pvcar_defs.vh ***
// Constants for the port VC arbitration register group
`ifndef PVCAR_DEFS_VH
`define PVCAR_DEFS_VH

// Printed register indices; the byte address is four times the index
`define PVCAR_IDX_PORT_VC_CONTROL 12'h20C
`define PVCAR_IDX_PORT_VC_STATUS 12'h20E
`define PVCAR_IDX_VC_RES0_CAP 12'h210
`define PVCAR_ADDR_PORT_VC_CONTROL 14'h0830
`define PVCAR_ADDR_PORT_VC_STATUS 14'h0838
`define PVCAR_ADDR_VC_RES0_CAP 14'h0840
`define PVCAR_ADDR_W 14

// Port VC control fields
`define PVCAR_CTL_TABLE_LOAD_BIT 0
`define PVCAR_CTL_SCHEME_LSB 1
`define PVCAR_CTL_SCHEME_MSB 3
`define PVCAR_CTL_SCHEME_RESET 3'h0

// Port VC status fields
`define PVCAR_STS_TABLE_STATUS_BIT 0

// VC resource 0 capability fields
`define PVCAR_CAP_ARB_LSB 0
`define PVCAR_CAP_ARB_MSB 7
`define PVCAR_CAP_ADV_SWITCH_BIT 14
`define PVCAR_CAP_REJECT_SNOOP_BIT 15
`define PVCAR_CAP_MAX_SLOTS_LSB 16
`define PVCAR_CAP_MAX_SLOTS_MSB 22
`define PVCAR_CAP_TBL_OFF_LSB 24
`define PVCAR_CAP_TBL_OFF_MSB 31

// Capability values per port role
`define PVCAR_ARB_CAP_UP 8'h03
`define PVCAR_ARB_CAP_DOWN 8'h01
`define PVCAR_TBL_OFF_UP 8'h02
`define PVCAR_TBL_OFF_DOWN 8'h00
`define PVCAR_MAX_SLOTS 7'h00

// Port arbitration capability bit meanings
`define PVCAR_ARB_FIXED_RR 0
`define PVCAR_ARB_WRR32 1
`define PVCAR_ARB_WRR64 2
`define PVCAR_ARB_WRR128 3
`define PVCAR_ARB_TBWRR128 4
`define PVCAR_ARB_WRR256 5

`endif

// *** test/pvcar_regs_props.sv ***
// Assertions on the port VC register group ports
`timescale 1ns/100ps
`default_nettype none
`include "pvcar_defs.vh"
module pvcar_regs_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Role and configuration
   input wire logic port_is_upstream,
   input wire logic [2:0] vc_scheme_select,
   input wire logic [7:0] port_arb_capability,
   input wire logic [7:0] port_arb_table_offset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd = pready && !pwrite;
   wire ctl = paddr == `PVCAR_ADDR_PORT_VC_CONTROL;
   wire sts = paddr == `PVCAR_ADDR_PORT_VC_STATUS;
   wire cp = paddr == `PVCAR_ADDR_VC_RES0_CAP;
   wire wr = pready && pwrite && ctl;
   wire [2:0] wsel = pwdata[3:1];
   property p_load; rd && ctl |-> !prdata[0]; endproperty
   a_load: assert property (p_load) else $error("load bit read one");
   property p_rsv; rd && ctl |-> prdata[31:4] == 28'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_sel; wr && pstrb[0] |=> vc_scheme_select == $past(wsel); endproperty
   a_sel: assert property (p_sel) else $error("selector not written");
   property p_hold; !wr |=> $stable(vc_scheme_select); endproperty
   a_hold: assert property (p_hold) else $error("selector changed");
   property p_sts; rd && sts |-> prdata == 32'h0; endproperty
   a_sts: assert property (p_sts) else $error("status not zero");
   property p_cap; rd && cp |-> prdata == {port_arb_table_offset, 16'h0, port_arb_capability};
   endproperty
   a_cap: assert property (p_cap) else $error("capability word wrong");
   property p_off; port_arb_table_offset == (port_arb_capability == 8'h03 ? 8'h02 : 8'h00);
   endproperty
   a_off: assert property (p_off) else $error("offset against role");
   property p_err; pready && !ctl && !sts && !cp |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok; pready && (ctl || sts || cp) |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   // Strap passes two sync flops and the output flop: three cycles late
   property p_role; $past(presetn, 3) && $past(presetn, 2) && $past(presetn) |->
      port_arb_capability == ($past(port_is_upstream, 3) ?
      `PVCAR_ARB_CAP_UP : `PVCAR_ARB_CAP_DOWN);
   endproperty
   a_role: assert property (p_role) else $error("capability against strap");
endmodule // pvcar_regs_props
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the port VC register group
`timescale 1ns/100ps
`default_nettype none
`include "pvcar_defs.vh"
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, up = 1, pready, pslverr, e;
   logic [13:0] paddr = 14'h0;
   logic [3:0] strb = 4'hF;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0] sel;
   logic [7:0] cap, off;
   int failures = 0, check_count = 0;
   initial forever #2.5 pclk = ~pclk;
   pvcar_regs pvcar_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_is_upstream(up),
      .vc_scheme_select(sel), .port_arb_capability(cap), .port_arb_table_offset(off));
   task end_of_test;
      $display("failures %0d checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         end_of_test;
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task t_ctl;
      apb(0, `PVCAR_ADDR_PORT_VC_CONTROL, 32'h0);
      chk(r, 32'h0);
      apb(1, `PVCAR_ADDR_PORT_VC_CONTROL, 32'hFFFFFFFF);
      chk(sel, 32'h7);
      apb(0, `PVCAR_ADDR_PORT_VC_CONTROL, 32'h0);
      chk(r, 32'hE);
      apb(1, `PVCAR_ADDR_PORT_VC_CONTROL, 32'h5);
      chk({off, cap, 13'h0, sel}, 32'h02030002);
      // Selector lives in byte 0, so a write without that strobe leaves it alone
      strb <= 4'hE;
      apb(1, `PVCAR_ADDR_PORT_VC_CONTROL, 32'hFFFFFFFF);
      strb <= 4'hF;
      chk(sel, 32'h2);
   endtask
   task t_sts;
      apb(1, `PVCAR_ADDR_PORT_VC_STATUS, 32'hFFFFFFFF);
      apb(0, `PVCAR_ADDR_PORT_VC_STATUS, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h0);
   endtask
   task t_rst;
      apb(1, `PVCAR_ADDR_PORT_VC_CONTROL, 32'h0000000E);
      presetn <= 0;
      repeat (3) @(posedge pclk);
      chk({off, cap, 13'h0, sel}, 32'h0);
      presetn <= 1;
      apb(0, `PVCAR_ADDR_PORT_VC_CONTROL, 32'h0);
      chk(r, 32'h0);
   endtask
   task t_err;
      apb(0, 14'h0834, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask
   task t_cap(input logic u, input logic [31:0] x);
      up <= u;
      repeat (4) @(posedge pclk);
      apb(1, `PVCAR_ADDR_VC_RES0_CAP, 32'hFFFFFFFF);
      apb(0, `PVCAR_ADDR_VC_RES0_CAP, 32'h0);
      chk(r, x);
      chk({off, 16'h0, cap}, x);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (3) @(posedge pclk);
      t_ctl;
      t_sts;
      t_rst;
      t_cap(1, 32'h02000003);
      t_cap(0, 32'h00000001);
      t_err;
      end_of_test;
   end
endmodule // tb
bind pvcar_regs pvcar_regs_props pvcar_regs_props_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_is_upstream,
   .vc_scheme_select, .port_arb_capability, .port_arb_table_offset);
`default_nettype wire
